/* hdl/pssd_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "pssd_consts.vh"
module pssd_top #(
    parameter DEB_CYC = `PSSD_DEB_CYC,
    parameter RETRY_CYC = `PSSD_RETRY_CYC,
    parameter CNT_W = 32
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_arst_n,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // comparators and events
    input wire i_usb_power_raw,
    input wire i_adapter_sense,
    input wire i_battery_raw,
    input wire i_soc_thermal_trip_n,
    input wire i_die_overtemp_event,
    input wire i_sys_overtemp_event,
    input wire i_batt_overtemp_event,
    input wire i_sys_temp_action_en,
    input wire i_batt_temp_action_en,
    input wire i_sys_rail_undervolt_event,
    input wire i_sys_rail_overvolt_event,
    input wire i_vbat_removal_event,
    input wire i_id_removal_event,
    input wire i_critical_voltage_zone,
    input wire i_crit_voltage_action_cfg,
    input wire i_battery_low,
    input wire i_soc_sleep,
    // outputs
    output reg o_shutdown_out_n,
    output reg o_regulators_off,
    output reg o_seq_shutdown_req,
    output reg o_battery_measure_req,
    output reg o_power_source_irq,
    output reg o_crit_voltage_irq,
    output reg o_battery_digital_if_en,
    output reg [2:0] o_wake_en,
    output reg o_adapter_only_boot,
    output reg [7:0] o_thresholds_a,
    output reg [7:0] o_thresholds_b
);
    localparam [CNT_W-1:0] OFF_CYC = `PSSD_OFF_CYC;
    localparam [CNT_W-1:0] FILT_CYC = `PSSD_FILT_CYC;
    localparam [CNT_W-1:0] DEB_N = DEB_CYC;
    localparam [CNT_W-1:0] RETRY_N = RETRY_CYC;
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_OFF = 2'h2;

    reg [2:0] change_flags;
    reg [2:0] mask_act;
    reg [2:0] mask_slp;
    reg [2:0] status;
    reg [5:0] cfg;
    reg [7:0] cause_a;
    reg [1:0] cause_b;
    reg [CNT_W-1:0] deb_cnt [0:2];
    reg [CNT_W-1:0] uv_cnt;
    reg [CNT_W-1:0] ov_cnt;
    reg [CNT_W-1:0] off_cnt;
    reg [CNT_W-1:0] retry_cnt;
    reg [1:0] state;
    reg [2:0] next_status;
    reg [7:0] next_cause;
    reg [1:0] next_seq;
    reg immediate;
    reg no_delay;
    integer k;
    integer j;

    wire [2:0] raw = {i_battery_raw, i_adapter_sense, i_usb_power_raw};
    wire uv_hit = (uv_cnt >= FILT_CYC);
    wire ov_hit = (ov_cnt >= FILT_CYC);
    // removal source chosen by config bit
    wire vbat_rm = i_vbat_removal_event & ~cfg[`PSSD_CFG_RMSRC];
    wire id_rm = i_id_removal_event & cfg[`PSSD_CFG_RMSRC];
    // removal shutdown (vbat cold off, id sequenced) unless disabled and adapter present
    wire rm_off = cfg[`PSSD_CFG_RMEN] | ~status[`PSSD_SRC_ADP];

    // immediate and sequenced shutdown cause decode
    always @* begin
        next_cause = 8'h00;
        next_cause[`PSSD_CA_TRIP] = ~i_soc_thermal_trip_n;
        next_cause[`PSSD_CA_DIE] = i_die_overtemp_event;
        next_cause[`PSSD_CA_SYS] = i_sys_overtemp_event & i_sys_temp_action_en;
        next_cause[`PSSD_CA_BATT] = i_batt_overtemp_event & i_batt_temp_action_en;
        next_cause[`PSSD_CA_UV] = uv_hit;
        next_cause[`PSSD_CA_OV] = ov_hit;
        next_cause[`PSSD_CA_RM] = vbat_rm & rm_off;
        immediate = |next_cause;
        no_delay = ov_hit;
        next_seq = 2'h0;
        next_seq[`PSSD_CB_IDRM] = id_rm & rm_off;
        next_seq[`PSSD_CB_CRITICAL_VOLTAGE_ZONE] = i_critical_voltage_zone & i_crit_voltage_action_cfg;
    end

    // debounced status: change only after a steady window when enabled
    always @* begin
        next_status = status;
        for (k = 0; k < 3; k = k + 1) begin
            if (!cfg[k]) begin
                next_status[k] = raw[k];
            end else if (raw[k] != status[k] && deb_cnt[k] >= DEB_N - 1) begin
                next_status[k] = raw[k];
            end
        end
    end

    // debounce counters
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            deb_cnt[0] <= {CNT_W{1'b0}};
            deb_cnt[1] <= {CNT_W{1'b0}};
            deb_cnt[2] <= {CNT_W{1'b0}};
        end else begin
            for (j = 0; j < 3; j = j + 1) begin
                if (raw[j] == status[j] || next_status[j] != status[j]) begin
                    deb_cnt[j] <= {CNT_W{1'b0}};
                end else begin
                    deb_cnt[j] <= deb_cnt[j] + 1'b1;
                end
            end
        end
    end

    // rail comparator persistence filters
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            uv_cnt <= {CNT_W{1'b0}};
            ov_cnt <= {CNT_W{1'b0}};
        end else begin
            if (!i_sys_rail_undervolt_event) begin
                uv_cnt <= {CNT_W{1'b0}};
            end else if (!uv_hit) begin
                uv_cnt <= uv_cnt + 1'b1;
            end
            if (!i_sys_rail_overvolt_event) begin
                ov_cnt <= {CNT_W{1'b0}};
            end else if (!ov_hit) begin
                ov_cnt <= ov_cnt + 1'b1;
            end
        end
    end

    // cold off sequencer
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_RUN;
            off_cnt <= {CNT_W{1'b0}};
            o_shutdown_out_n <= 1'b1;
            o_regulators_off <= 1'b0;
            o_seq_shutdown_req <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (immediate) begin
                        o_shutdown_out_n <= 1'b0;
                        off_cnt <= {CNT_W{1'b0}};
                        if (no_delay) begin
                            o_regulators_off <= 1'b1;
                            state <= ST_OFF;
                        end else begin
                            state <= ST_DELAY;
                        end
                    end else if (|next_seq) begin
                        o_seq_shutdown_req <= 1'b1;
                    end
                end
                ST_DELAY: begin
                    off_cnt <= off_cnt + 1'b1;
                    if (off_cnt >= OFF_CYC - 1) begin
                        o_regulators_off <= 1'b1;
                        state <= ST_OFF;
                    end
                end
                ST_OFF: begin
                    state <= ST_OFF;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // shutdown cause capture, held until reset except that an immediate cause replaces a sequenced one; a read does not clear it
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cause_a <= 8'h00;
            cause_b <= 2'h0;
        end else if (state == ST_RUN) begin
            if (immediate) begin
                cause_a <= next_cause;
                cause_b <= 2'h0;
            end else if ((|next_seq) && !o_seq_shutdown_req) begin
                cause_a <= 8'h00;
                cause_b <= next_seq;
            end
        end
    end

    // status, change flags and register writes
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status <= 3'h0;
            change_flags <= 3'h0;
            mask_act <= `PSSD_RST_MASK;
            mask_slp <= `PSSD_RST_MASK;
            cfg <= `PSSD_RST_CFG;
            o_thresholds_a <= `PSSD_RST_THR_A;
            o_thresholds_b <= `PSSD_RST_THR_B;
            o_wake_en <= 3'h0;
        end else begin
            status <= next_status;
            // write-one clears; a new change in the same cycle wins
            change_flags <= (change_flags & ~((i_reg_wr && i_reg_addr == `PSSD_ADR_FLAGS) ?
                i_reg_wdata[2:0] : 3'h0)) | (next_status ^ status);
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `PSSD_ADR_MASK_ACT: mask_act <= i_reg_wdata[2:0];
                    `PSSD_ADR_MASK_SLP: mask_slp <= i_reg_wdata[2:0];
                    `PSSD_ADR_CFG: cfg <= i_reg_wdata[5:0];
                    `PSSD_ADR_THR_A: o_thresholds_a <= i_reg_wdata;
                    `PSSD_ADR_THR_B: o_thresholds_b <= i_reg_wdata;
                    `PSSD_ADR_WAKE: o_wake_en <= i_reg_wdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // read mux and registered outputs
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 8'h00;
            o_power_source_irq <= 1'b0;
            o_crit_voltage_irq <= 1'b0;
            o_battery_digital_if_en <= 1'b0;
            o_adapter_only_boot <= 1'b0;
        end else begin
            o_power_source_irq <= |(change_flags & ~(i_soc_sleep ? mask_slp : mask_act));
            o_crit_voltage_irq <= i_critical_voltage_zone & ~i_crit_voltage_action_cfg;
            o_battery_digital_if_en <= cfg[`PSSD_CFG_DBI];
            o_adapter_only_boot <= o_thresholds_a[`PSSD_THR_BOOT];
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `PSSD_ADR_FLAGS: o_reg_rdata <= {5'h00, change_flags};
                    `PSSD_ADR_MASK_ACT: o_reg_rdata <= {5'h00, mask_act};
                    `PSSD_ADR_MASK_SLP: o_reg_rdata <= {5'h00, mask_slp};
                    `PSSD_ADR_STATUS: o_reg_rdata <= {5'h00, status};
                    `PSSD_ADR_CAUSE_A: o_reg_rdata <= cause_a;
                    `PSSD_ADR_CAUSE_B: o_reg_rdata <= {6'h00, cause_b};
                    `PSSD_ADR_THR_A: o_reg_rdata <= o_thresholds_a;
                    `PSSD_ADR_THR_B: o_reg_rdata <= o_thresholds_b;
                    `PSSD_ADR_CFG: o_reg_rdata <= {2'h0, cfg};
                    `PSSD_ADR_WAKE: o_reg_rdata <= {5'h00, o_wake_en};
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // periodic battery re-measure while usb present and battery low
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            retry_cnt <= {CNT_W{1'b0}};
            o_battery_measure_req <= 1'b0;
        end else begin
            o_battery_measure_req <= 1'b0;
            if (!(status[`PSSD_SRC_USB] && i_battery_low)) begin
                retry_cnt <= {CNT_W{1'b0}};
            end else if (retry_cnt >= RETRY_N - 1) begin
                retry_cnt <= {CNT_W{1'b0}};
                o_battery_measure_req <= 1'b1;
            end else begin
                retry_cnt <= retry_cnt + 1'b1;
            end
        end
    end
endmodule // pssd_top
`default_nettype wire

/* hdl/pssd_consts.vh */
`ifndef PSSD_CONSTS_VH
`define PSSD_CONSTS_VH
`define PSSD_CLK_MHZ 100
`define PSSD_OFF_DELAY_NS 90000
`define PSSD_OFF_CYC ((`PSSD_OFF_DELAY_NS * `PSSD_CLK_MHZ) / 1000)
`define PSSD_FILT_NS 100000
`define PSSD_FILT_CYC (((`PSSD_FILT_NS * `PSSD_CLK_MHZ) + 999) / 1000 + 1)
`define PSSD_DEB_MS 100
`define PSSD_DEB_CYC (`PSSD_DEB_MS * 1000 * `PSSD_CLK_MHZ)
`define PSSD_RETRY_MS 4000
`define PSSD_RETRY_CYC (`PSSD_RETRY_MS * 1000 * `PSSD_CLK_MHZ)
`define PSSD_ADR_FLAGS 8'h03
`define PSSD_ADR_MASK_ACT 8'h0F
`define PSSD_ADR_MASK_SLP 8'h10
`define PSSD_ADR_STATUS 8'h1E
`define PSSD_ADR_CAUSE_A 8'h20
`define PSSD_ADR_CAUSE_B 8'h21
`define PSSD_ADR_THR_A 8'h23
`define PSSD_ADR_THR_B 8'h24
`define PSSD_ADR_CFG 8'h25
`define PSSD_ADR_WAKE 8'hDB
`define PSSD_RST_MASK 3'h7
`define PSSD_RST_THR_A 8'hCB
`define PSSD_RST_THR_B 8'h8A
`define PSSD_RST_CFG 6'h07
`define PSSD_CFG_RMEN 3
`define PSSD_CFG_RMSRC 4
`define PSSD_CFG_DBI 5
`define PSSD_THR_BOOT 7
`define PSSD_SRC_USB 0
`define PSSD_SRC_ADP 1
`define PSSD_SRC_BAT 2
`define PSSD_CA_TRIP 0
`define PSSD_CA_DIE 1
`define PSSD_CA_SYS 3
`define PSSD_CA_BATT 4
`define PSSD_CA_UV 5
`define PSSD_CA_OV 6
`define PSSD_CA_RM 7
`define PSSD_CB_CRITICAL_VOLTAGE_ZONE 0
`define PSSD_CB_IDRM 1
`endif

/* tb/pssd_soc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pssd_soc_model (
    // clock
    input wire logic i_ref_clk,
    // over-temperature request from the scenario
    input wire logic i_trip_req,
    // thermal trip pin towards the device
    output logic o_soc_thermal_trip_n
);
    // pin idles high and is pulled low while the soc is too hot
    initial o_soc_thermal_trip_n = 1'b1;
    always @(negedge i_ref_clk) begin
        o_soc_thermal_trip_n <= ~i_trip_req;
    end
endmodule // pssd_soc_model
`default_nettype wire

/* tb/pssd_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pssd_top_asserts (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // watched inputs
    input wire logic i_reg_rd,
    input wire logic i_soc_thermal_trip_n,
    input wire logic i_die_overtemp_event,
    input wire logic i_sys_rail_undervolt_event,
    input wire logic i_sys_rail_overvolt_event,
    input wire logic i_critical_voltage_zone,
    input wire logic i_crit_voltage_action_cfg,
    // watched outputs
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_shutdown_out_n,
    input wire logic o_regulators_off,
    input wire logic o_seq_shutdown_req,
    input wire logic o_battery_measure_req
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    logic [14:0] off_cnt;
    logic [14:0] uv_cnt;
    // cycles since shutdown went low, and saturating undervoltage run length
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            off_cnt <= 15'h0000;
            uv_cnt <= 15'h0000;
        end else begin
            off_cnt <= o_shutdown_out_n ? 15'h0000 : off_cnt + 15'h0001;
            uv_cnt <= i_sys_rail_undervolt_event ? uv_cnt + {14'h0000, ~&uv_cnt} : 15'h0000;
        end
    end
    sequence s_trip_taken;
        $fell(i_soc_thermal_trip_n) && o_shutdown_out_n;
    endsequence
    sequence s_critical_voltage_zone_shut;
        i_critical_voltage_zone && i_crit_voltage_action_cfg;
    endsequence
    a_trip_shuts_now: assert property (s_trip_taken |=> !o_shutdown_out_n) else $error("trip did not shut down");
    a_die_shuts_now: assert property (i_die_overtemp_event && o_shutdown_out_n |=> !o_shutdown_out_n)
        else $error("die overtemp did not shut down");
    a_off_delay_exact: assert property ($rose(o_regulators_off) |-> off_cnt == 15'd9000
        || ($fell(o_shutdown_out_n) && $past(i_sys_rail_overvolt_event))) else $error("regulator off timing");
    a_off_needs_shut: assert property (o_regulators_off |-> !o_shutdown_out_n) else $error("off before shutdown");
    a_shut_sticky: assert property (!o_shutdown_out_n |=> !o_shutdown_out_n[*2]) else $error("shutdown released");
    a_uv_fires: assert property (uv_cnt > 15'd10002 |-> !o_shutdown_out_n) else $error("undervoltage ignored");
    a_critical_voltage_zone_seq: assert property (s_critical_voltage_zone_shut |=> o_seq_shutdown_req) else $error("critical_voltage_zone no sequenced off");
    a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata)) else $error("read data moved");
    a_measure_pulse: assert property (o_battery_measure_req |=> !o_battery_measure_req) else $error("measure not a pulse");
endmodule // pssd_top_asserts
bind pssd_top pssd_top_asserts i_pssd_top_asserts (.i_ref_clk, .i_arst_n, .i_reg_rd, .i_soc_thermal_trip_n,
    .i_die_overtemp_event, .i_sys_rail_undervolt_event, .i_sys_rail_overvolt_event, .i_critical_voltage_zone,
    .i_crit_voltage_action_cfg, .o_reg_rdata, .o_shutdown_out_n, .o_regulators_off, .o_seq_shutdown_req,
    .o_battery_measure_req);
`default_nettype wire

/* tb/test_pssd_top.sv */
`timescale 1ns/100ps
`default_nettype none
module test_pssd_top;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [15:0] ev = 16'h0000;
    logic trip_n;
    logic [7:0] o_reg_rdata, o_thresholds_a, o_thresholds_b;
    logic [2:0] o_wake_en;
    logic sd_n, off, seq, meas, psirq, cvirq, dbi, aboot;
    int miscompares = 0;
    int samples_checked = 0;
    int n, k, d;
    logic [7:0] adr [11] = '{8'h03, 8'h0F, 8'h10, 8'h1E, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'hDB, 8'h50};
    logic [7:0] rv [11] = '{8'h00, 8'h07, 8'h07, 8'h00, 8'h00, 8'h00, 8'hCB, 8'h8A, 8'h07, 8'h00, 8'h00};
    int src [6] = '{3, 4, 5, 6, 9, 10};
    logic [7:0] cause [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
    // short debounce and retry counts keep the run brief
    pssd_top #(.DEB_CYC(20), .RETRY_CYC(50)) i_pssd_top (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_usb_power_raw(ev[0]), .i_adapter_sense(ev[1]), .i_battery_raw(ev[2]),
        .i_soc_thermal_trip_n(trip_n), .i_die_overtemp_event(ev[4]), .i_sys_overtemp_event(ev[5]),
        .i_batt_overtemp_event(ev[6]), .i_sys_temp_action_en(ev[7]), .i_batt_temp_action_en(ev[8]),
        .i_sys_rail_undervolt_event(ev[9]), .i_sys_rail_overvolt_event(ev[10]), .i_vbat_removal_event(ev[11]),
        .i_id_removal_event(ev[12]), .i_critical_voltage_zone(ev[13]), .i_crit_voltage_action_cfg(ev[14]),
        .i_battery_low(ev[15]), .i_soc_sleep(1'b0), .o_shutdown_out_n(sd_n), .o_regulators_off(off),
        .o_seq_shutdown_req(seq), .o_battery_measure_req(meas), .o_power_source_irq(psirq),
        .o_crit_voltage_irq(cvirq), .o_battery_digital_if_en(dbi), .o_wake_en(o_wake_en),
        .o_adapter_only_boot(aboot), .o_thresholds_a(o_thresholds_a), .o_thresholds_b(o_thresholds_b));
    pssd_soc_model i_pssd_soc_model (.i_ref_clk(i_ref_clk), .i_trip_req(ev[3]), .o_soc_thermal_trip_n(trip_n));
    // 100 MHz clock
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic results();
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic tick(int c);
        repeat (c) @(negedge i_ref_clk);
    endtask
    task automatic reset_dut();
        @(negedge i_ref_clk) i_arst_n = 1'b0;
        ev = 16'h0000;
        tick(12);
        i_arst_n = 1'b1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge i_ref_clk) {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, v};
        @(negedge i_ref_clk) i_reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge i_ref_clk) {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(negedge i_ref_clk) i_reg_rd = 1'b0;
        check($sformatf("reg %h", a), exp, o_reg_rdata);
    endtask
    // waits for shutdown, then counts cycles until the regulators drop
    task automatic wait_off(output int dly);
        n = 0;
        while (sd_n !== 1'b0 && n < 10100) begin
            tick(1);
            n++;
        end
        dly = 0;
        while (off !== 1'b1 && dly < 9100) begin
            tick(1);
            dly++;
        end
        if (n >= 10100 || dly >= 9100) begin
            miscompares++;
            results();
        end
    endtask
    // main sequence
    initial begin
        reset_dut();
        for (k = 0; k < 11; k++) rd(adr[k], rv[k]);
        check("thr", 16'h8ACB, {o_thresholds_b, o_thresholds_a});
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        wr(8'hDB, 8'h05);
        rd(8'hDB, 8'h05);
        check("wake", 16'h0005, o_wake_en);
        wr(8'h23, 8'h4B);
        wr(8'h25, 8'h27);
        tick(1);
        check("boot dbi", 16'h0001, {aboot, dbi});
        ev[0] = 1'b1;
        tick(8);
        rd(8'h1E, 8'h00);
        tick(20);
        rd(8'h1E, 8'h01);
        rd(8'h03, 8'h01);
        check("irq masked", 16'h0000, psirq);
        wr(8'h0F, 8'h06);
        tick(1);
        check("irq", 16'h0001, psirq);
        wr(8'h03, 8'h01);
        rd(8'h03, 8'h00);
        check("irq clr", 16'h0000, psirq);
        wr(8'h25, 8'h00);
        ev[1] = 1'b1;
        rd(8'h1E, 8'h03);
        ev[15] = 1'b1;
        d = 0;
        repeat (200) begin
            tick(1);
            if (meas === 1'b1) d++;
        end
        check("measure", 16'h0001, (d >= 3 && d <= 5));
        {ev[13], ev[14]} = 2'b10;
        tick(3);
        check("critical_voltage_zone irq", 16'h0002, {cvirq, seq});
        ev[14] = 1'b1;
        tick(3);
        check("critical_voltage_zone seq", 16'h0003, {seq, sd_n});
        rd(8'h21, 8'h01);
        for (k = 0; k < 6; k++) begin
            reset_dut();
            ev[src[k]] = 1'b1;
            if (k == 2 || k == 3) begin
                tick(5);
                check("gated", 16'h0001, sd_n);
                ev[src[k] + 2] = 1'b1;
            end
            if (k >= 4) begin
                tick(9990);
                check("early", 16'h0001, sd_n);
            end
            wait_off(d);
            check("off delay", (k == 5) ? 16'd0 : 16'd9000, d[15:0]);
            ev[4] = 1'b1;
            rd(8'h20, cause[k]);
        end
        reset_dut();
        wr(8'h25, 8'h08);
        ev[11] = 1'b1;
        wait_off(d);
        check("rm delay", 16'd9000, d[15:0]);
        rd(8'h20, 8'h80);
        reset_dut();
        wr(8'h25, 8'h00);
        ev[1] = 1'b1;
        tick(2);
        ev[11] = 1'b1;
        tick(20);
        check("rm kept", 16'h0001, sd_n);
        ev[1] = 1'b0;
        wait_off(d);
        check("rm no adp", 16'd9000, d[15:0]);
        reset_dut();
        ev[12] = 1'b1;
        tick(3);
        check("id src0", 16'h0000, seq);
        wr(8'h25, 8'h10);
        tick(3);
        check("id seq", 16'h0003, {seq, sd_n});
        rd(8'h21, 8'h02);
        results();
    end
endmodule // test_pssd_top
`default_nettype wire
